// >>> verilog/rda_arbiter.sv
`timescale 1ns/100ps
module rda_arbiter
  import rda_pkg::*;
(
  input  wire logic                         i_clk_sys,       // system clock
  input  wire logic                         i_reset_n,       // async reset, active low
  rda_if.dev                                bus,             // link to partner end
  output logic [rda_pkg::SYS_ADDR_W-1:0]    o_dma_sys_addr,  // full dma address
  output logic                              o_dma_addr_valid, // dma address is good
  output logic [rda_pkg::ROW_W-1:0]         o_next_row,      // next row to refresh
  output logic                              o_refresh_pending, // tick waiting
  output logic                              o_refresh_busy   // refresh access active
);
  import rda_pkg::*;

  // sweep time must fit both retention windows
  localparam int SWEEP_SHORT_NS = ROWS_SHORT * REFRESH_PERIOD_NS;
  localparam int SWEEP_LONG_NS  = ROWS_LONG * REFRESH_PERIOD_NS;
  localparam logic FITS_WINDOW  = (SWEEP_SHORT_NS <= RETAIN_SHORT_NS) &&
                                  (SWEEP_LONG_NS <= RETAIN_LONG_NS);
  localparam int RD_CNT_W       = 4;
  localparam logic [RD_CNT_W-1:0] RD_LAST = RD_CNT_W'(REFRESH_READ_CYCLES - 1);

  // ---------------------------------------------------------------
  // arbitration state
  // ---------------------------------------------------------------
  rda_arb_state_e        state_ff;
  rda_arb_state_e        nxt_state;
  logic                  hold_ff;
  logic                  nxt_hold;
  logic                  for_refresh_ff;
  logic                  nxt_for_refresh;
  logic                  pending_ff;
  logic                  nxt_pending;
  logic                  grant_ff;
  logic                  nxt_grant;
  logic [RD_CNT_W-1:0]   rd_cnt_ff;
  logic [RD_CNT_W-1:0]   nxt_rd_cnt;
  logic [ROW_W-1:0]      row_ff;
  logic [ROW_W-1:0]      nxt_row;
  logic                  row_done;
  logic                  want_refresh;

  assign want_refresh = pending_ff | bus.refresh_tick;
  assign row_done     = (state_ff == RDA_REFRESH) && (rd_cnt_ff == RD_LAST);

  always_comb begin
    nxt_state       = state_ff;
    nxt_hold        = hold_ff;
    nxt_for_refresh = for_refresh_ff;
    nxt_grant       = grant_ff;
    nxt_rd_cnt      = rd_cnt_ff;
    nxt_row         = row_ff;
    // a tick landing on the clearing cycle stays pending
    nxt_pending     = bus.refresh_tick | (pending_ff & ~row_done);
    case (state_ff)
      RDA_IDLE: begin
        if (want_refresh && FITS_WINDOW) begin
          nxt_hold        = 1'b1;
          nxt_for_refresh = 1'b1;
          nxt_state       = RDA_HOLD_WAIT;
        end else if (bus.dma_hold_req) begin
          nxt_hold        = 1'b1;
          nxt_for_refresh = 1'b0;
          nxt_state       = RDA_HOLD_WAIT;
        end
      end
      RDA_HOLD_WAIT: begin
        if (bus.cpu_hold_ack) begin
          if (for_refresh_ff || want_refresh) begin
            nxt_for_refresh = 1'b1;
            nxt_rd_cnt      = '0;
            nxt_state       = RDA_REFRESH;
          end else if (bus.dma_hold_req) begin
            nxt_grant = 1'b1;
            nxt_state = RDA_DMA;
          end else begin
            nxt_hold  = 1'b0;
            nxt_state = RDA_RELEASE;
          end
        end
      end
      RDA_REFRESH: begin
        nxt_rd_cnt = rd_cnt_ff + 1'b1;
        if (row_done) begin
          nxt_row   = row_ff + 1'b1;
          nxt_hold  = 1'b0;
          nxt_state = RDA_RELEASE;
        end
      end
      RDA_DMA: begin
        if (!bus.dma_hold_req) begin
          nxt_grant = 1'b0;
          if (want_refresh) begin
            nxt_for_refresh = 1'b1;
            nxt_rd_cnt      = '0;
            nxt_state       = RDA_REFRESH;
          end else begin
            nxt_hold  = 1'b0;
            nxt_state = RDA_RELEASE;
          end
        end
      end
      RDA_RELEASE: begin
        if (!bus.cpu_hold_ack) begin
          nxt_state = RDA_IDLE;
        end
      end
      default: begin
        nxt_state = RDA_IDLE;
        nxt_hold  = 1'b0;
        nxt_grant = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff       <= RDA_IDLE;
      hold_ff        <= 1'b0;
      for_refresh_ff <= 1'b0;
      pending_ff     <= 1'b0;
      grant_ff       <= 1'b0;
      rd_cnt_ff      <= '0;
      row_ff         <= ROW_RESET;
    end else begin
      state_ff       <= nxt_state;
      hold_ff        <= nxt_hold;
      for_refresh_ff <= nxt_for_refresh;
      pending_ff     <= nxt_pending;
      grant_ff       <= nxt_grant;
      rd_cnt_ff      <= nxt_rd_cnt;
      row_ff         <= nxt_row;
    end
  end

  // ---------------------------------------------------------------
  // refresh access, cpu hold and dma grant outputs
  // ---------------------------------------------------------------
  logic refreshing;
  assign refreshing          = (state_ff == RDA_REFRESH);
  assign bus.cpu_hold_req    = hold_ff;
  assign bus.refresh_cycle   = refreshing;
  assign bus.row_addr_out    = row_ff;
  assign bus.row_addr_oe_n   = ~refreshing;
  assign bus.sys_mem_read_n  = ~refreshing;
  assign bus.dma_hold_grant  = grant_ff;
  assign o_next_row          = row_ff;
  assign o_refresh_pending   = pending_ff;
  assign o_refresh_busy      = refreshing;

  // ---------------------------------------------------------------
  // dma address path
  // ---------------------------------------------------------------
  logic [7:0]             hi_ff;
  logic [7:0]             nxt_hi;
  logic                   hi_seen_ff;
  logic                   nxt_hi_seen;
  logic [PAGE_W-1:0]      page_ff;
  logic [PAGE_W-1:0]      nxt_page;
  logic [SYS_ADDR_W-1:0]  addr_ff;
  logic [SYS_ADDR_W-1:0]  nxt_addr;
  logic                   valid_ff;
  logic                   nxt_valid;
  logic [DMA_ADDR_W-1:0]  ctrl_addr;

  always_comb begin
    nxt_hi      = hi_ff;
    nxt_hi_seen = hi_seen_ff & grant_ff;
    nxt_page    = page_ff;
    nxt_addr    = addr_ff;
    nxt_valid   = 1'b0;
    if (bus.page_wr) begin
      nxt_page = bus.page_data;
    end
    if (bus.upper_addr_latch_strobe) begin
      nxt_hi      = bus.dma_data_hi;
      nxt_hi_seen = 1'b1;
    end
    ctrl_addr = {nxt_hi, bus.dma_addr_lo};
    if (bus.dma_word) begin
      // word controller: lines 1..16, page on 17..23
      nxt_addr = {page_ff[PAGE_W-1:1], ctrl_addr, 1'b0};
    end else begin
      // byte controller: lines 0..15, page on 16..23
      nxt_addr = {page_ff, ctrl_addr};
    end
    nxt_valid = grant_ff & nxt_hi_seen;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_ff      <= 8'h00;
      hi_seen_ff <= 1'b0;
      page_ff    <= PAGE_RESET;
      addr_ff    <= '0;
      valid_ff   <= 1'b0;
    end else begin
      hi_ff      <= nxt_hi;
      hi_seen_ff <= nxt_hi_seen;
      page_ff    <= nxt_page;
      addr_ff    <= nxt_addr;
      valid_ff   <= nxt_valid;
    end
  end

  assign o_dma_sys_addr   = addr_ff;
  assign o_dma_addr_valid = valid_ff;

endmodule

// >>> verilog/rda_pkg.sv
package rda_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ             = 20000;
  localparam int REFRESH_PERIOD_NS   = 15000;
  localparam int TICK_CYCLES         = (REFRESH_PERIOD_NS * CLK_KHZ) / 1000000;
  localparam int REFRESH_READ_NS     = 200;
  localparam int REFRESH_READ_CYCLES = (REFRESH_READ_NS * CLK_KHZ + 999999) / 1000000;
  localparam int DMA_XFER_CYCLES     = 4;

  // full sweep of rows, must finish inside the retention window
  localparam int ROWS_SHORT          = 128;
  localparam int ROWS_LONG           = 256;
  localparam int RETAIN_SHORT_NS     = 2000000;
  localparam int RETAIN_LONG_NS      = 4000000;

  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int ROW_W               = 8;
  localparam int SYS_ADDR_W          = 24;
  localparam int DMA_ADDR_W          = 16;
  localparam int PAGE_W              = 8;
  localparam logic [ROW_W-1:0] ROW_RESET   = 8'h00;
  localparam logic [ROW_W-1:0] ROW_LAST    = 8'hff;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RDA_IDLE,
    RDA_HOLD_WAIT,
    RDA_REFRESH,
    RDA_DMA,
    RDA_RELEASE
  } rda_arb_state_e;

  typedef enum logic [2:0] {
    RDA_P_IDLE,
    RDA_P_REQ,
    RDA_P_STROBE,
    RDA_P_XFER,
    RDA_P_DONE
  } rda_dma_state_e;

endpackage

// >>> verilog/rda_if.sv
`timescale 1ns/100ps
interface rda_if;
  import rda_pkg::*;

  logic                  refresh_tick;            // timer tick, one cycle
  logic                  cpu_hold_req;            // arbiter asks cpu for bus
  logic                  cpu_hold_ack;            // cpu has let go of bus
  logic                  refresh_cycle;           // refresh access active
  logic                  sys_mem_read_n;          // forced memory read
  logic [ROW_W-1:0]      row_addr_out;            // row value toward low address lines
  logic                  row_addr_oe_n;           // low while row is driven
  logic                  dma_hold_req;            // dma controller wants bus
  logic                  dma_hold_grant;          // arbiter grants dma
  logic                  dma_word;                // word controller in use
  logic [7:0]            dma_addr_lo;             // low byte on address pins
  logic [7:0]            dma_data_hi;             // high byte on data pins
  logic                  upper_addr_latch_strobe; // captures high byte
  logic                  page_wr;                 // page register write
  logic [PAGE_W-1:0]     page_data;               // page number

  // resolved low address lines, pulled low while the row driver is off
  wire  [ROW_W-1:0]      sys_addr_lo;
  assign sys_addr_lo = row_addr_oe_n ? 8'h00 : row_addr_out;

  modport dev (
    input  refresh_tick, cpu_hold_ack, dma_hold_req, dma_word, dma_addr_lo,
           dma_data_hi, upper_addr_latch_strobe, page_wr, page_data,
    output cpu_hold_req, refresh_cycle, sys_mem_read_n, row_addr_out,
           row_addr_oe_n, dma_hold_grant
  );

  modport partner (
    output refresh_tick, cpu_hold_ack, dma_hold_req, dma_word, dma_addr_lo,
           dma_data_hi, upper_addr_latch_strobe, page_wr, page_data,
    input  cpu_hold_req, refresh_cycle, sys_mem_read_n, row_addr_out,
           row_addr_oe_n, dma_hold_grant
  );

endinterface

// >>> verilog/rda_partner.sv
`timescale 1ns/100ps
module rda_partner
  import rda_pkg::*;
(
  input  wire logic                          i_clk_sys,        // system clock
  input  wire logic                          i_reset_n,        // async reset, active low
  rda_if.partner                             bus,              // link to arbiter
  input  wire logic                          i_dev_dma_request, // peripheral wants dma
  input  wire logic                          i_word_xfer,      // 1 word, 0 byte
  input  wire logic [rda_pkg::DMA_ADDR_W-1:0] i_xfer_addr,     // controller address
  input  wire logic                          i_page_wr,        // software page write
  input  wire logic [rda_pkg::PAGE_W-1:0]    i_page_data,      // page number
  output logic                               o_dev_dma_grant,  // peripheral acknowledge
  output logic                               o_cpu_held        // cpu off the bus
);
  import rda_pkg::*;

  localparam int TICK_W = 9;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int XF_W = 3;
  localparam logic [XF_W-1:0] XF_LAST = XF_W'(DMA_XFER_CYCLES - 1);

  // ---------------------------------------------------------------
  // timer, cpu hold and page write
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [TICK_W-1:0] nxt_tick_cnt;
  logic              tick_ff;
  logic              nxt_tick;
  logic              ack_ff;
  logic              nxt_ack;
  logic              pwr_ff;
  logic              nxt_pwr;
  logic [PAGE_W-1:0] pdata_ff;
  logic [PAGE_W-1:0] nxt_pdata;

  always_comb begin
    nxt_tick     = (tick_cnt_ff == TICK_LAST);
    nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + 1'b1;
    nxt_ack      = bus.cpu_hold_req;
    nxt_pwr      = i_page_wr;
    nxt_pdata    = i_page_wr ? i_page_data : pdata_ff;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
      ack_ff      <= 1'b0;
      pwr_ff      <= 1'b0;
      pdata_ff    <= PAGE_RESET;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
      ack_ff      <= nxt_ack;
      pwr_ff      <= nxt_pwr;
      pdata_ff    <= nxt_pdata;
    end
  end

  assign bus.refresh_tick = tick_ff;
  assign bus.cpu_hold_ack = ack_ff;
  assign bus.page_wr      = pwr_ff;
  assign bus.page_data    = pdata_ff;
  assign o_cpu_held       = ack_ff;

  // ---------------------------------------------------------------
  // dma controller
  // ---------------------------------------------------------------
  rda_dma_state_e          dstate_ff;
  rda_dma_state_e          nxt_dstate;
  logic [XF_W-1:0]         xf_cnt_ff;
  logic [XF_W-1:0]         nxt_xf_cnt;
  logic [DMA_ADDR_W-1:0]   addr_ff;
  logic [DMA_ADDR_W-1:0]   nxt_addr;
  logic                    word_ff;
  logic                    nxt_word;

  always_comb begin
    nxt_dstate = dstate_ff;
    nxt_xf_cnt = xf_cnt_ff;
    nxt_addr   = addr_ff;
    nxt_word   = word_ff;
    case (dstate_ff)
      RDA_P_IDLE: begin
        if (i_dev_dma_request) begin
          nxt_addr   = i_xfer_addr;
          nxt_word   = i_word_xfer;
          nxt_dstate = RDA_P_REQ;
        end
      end
      RDA_P_REQ: begin
        if (bus.dma_hold_grant) begin
          nxt_dstate = RDA_P_STROBE;
        end
      end
      RDA_P_STROBE: begin
        nxt_xf_cnt = '0;
        nxt_dstate = RDA_P_XFER;
      end
      RDA_P_XFER: begin
        nxt_xf_cnt = xf_cnt_ff + 1'b1;
        if (xf_cnt_ff == XF_LAST) begin
          nxt_dstate = RDA_P_DONE;
        end
      end
      RDA_P_DONE: begin
        if (!bus.dma_hold_grant) begin
          nxt_dstate = RDA_P_IDLE;
        end
      end
      default: nxt_dstate = RDA_P_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dstate_ff <= RDA_P_IDLE;
      xf_cnt_ff <= '0;
      addr_ff   <= '0;
      word_ff   <= 1'b0;
    end else begin
      dstate_ff <= nxt_dstate;
      xf_cnt_ff <= nxt_xf_cnt;
      addr_ff   <= nxt_addr;
      word_ff   <= nxt_word;
    end
  end

  assign bus.dma_hold_req = (dstate_ff == RDA_P_REQ) || (dstate_ff == RDA_P_STROBE) ||
                            (dstate_ff == RDA_P_XFER);
  assign bus.upper_addr_latch_strobe = (dstate_ff == RDA_P_STROBE);
  assign bus.dma_data_hi  = addr_ff[15:8];
  assign bus.dma_addr_lo  = addr_ff[7:0];
  assign bus.dma_word     = word_ff;
  assign o_dev_dma_grant  = (dstate_ff == RDA_P_XFER);

endmodule

// >>> dv/rda_assertions.sv
`timescale 1ns/100ps
module rda_assertions
  import rda_pkg::*;
(
  input wire logic                    i_clk_sys,      // system clock
  input wire logic                    i_reset_n,      // async reset, active low
  input wire logic                    refresh_tick,   // timer tick
  input wire logic                    cpu_hold_req,   // hold to cpu
  input wire logic                    cpu_hold_ack,   // cpu hold ack
  input wire logic                    refresh_cycle,  // refresh active
  input wire logic                    sys_mem_read_n, // forced read
  input wire logic [rda_pkg::ROW_W-1:0] row_addr_out, // row counter
  input wire logic                    row_addr_oe_n,  // row drive enable
  input wire logic                    dma_hold_req,   // dma wants bus
  input wire logic                    dma_hold_grant, // dma granted
  input wire logic [rda_pkg::ROW_W-1:0] sys_addr_lo   // resolved low lines
);
  // ---------------------------------------------------------------
  // tick seen but row not yet refreshed
  // ---------------------------------------------------------------
  logic tick_seen_ff;
  logic cycle_d_ff;
  logic nxt_tick_seen;

  always_comb begin
    nxt_tick_seen = tick_seen_ff;
    if (cycle_d_ff && !refresh_cycle) nxt_tick_seen = 1'b0;
    if (refresh_tick) nxt_tick_seen = 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_seen_ff <= 1'b0;
      cycle_d_ff   <= 1'b0;
    end else begin
      tick_seen_ff <= nxt_tick_seen;
      cycle_d_ff   <= refresh_cycle;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_refresh_body; refresh_cycle [*4] ##1 !refresh_cycle; endsequence
  sequence s_refresh_end; $fell(refresh_cycle); endsequence

  property p_read_strobe; sys_mem_read_n == !refresh_cycle; endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe not tied to refresh");
  property p_row_lines; (row_addr_oe_n == !refresh_cycle) && (!refresh_cycle || sys_addr_lo == row_addr_out); endproperty
  a_row_lines: assert property (p_row_lines) else $error("row lines driven wrongly");
  property p_refresh_len; $rose(refresh_cycle) |-> s_refresh_body; endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("refresh access length wrong");
  property p_ack_first; refresh_cycle |-> cpu_hold_ack && cpu_hold_req; endproperty
  a_ack_first: assert property (p_ack_first) else $error("refresh without hold ack");
  property p_row_step; s_refresh_end |-> row_addr_out == $past(row_addr_out) + 8'h01; endproperty
  a_row_step: assert property (p_row_step) else $error("row did not step");
  property p_row_hold; !$fell(refresh_cycle) |-> $stable(row_addr_out); endproperty
  a_row_hold: assert property (p_row_hold) else $error("row moved outside refresh");
  property p_hold_drop; s_refresh_end |-> !cpu_hold_req; endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("hold kept after row");
  property p_tick_hold; refresh_tick && !dma_hold_grant |-> ##[1:4] cpu_hold_req; endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick raised no hold");
  property p_no_grant_pending; $rose(dma_hold_grant) |-> !tick_seen_ff; endproperty
  a_no_grant_pending: assert property (p_no_grant_pending) else $error("dma granted over refresh");
  property p_grant_held; dma_hold_grant |-> cpu_hold_ack && !refresh_cycle; endproperty
  a_grant_held: assert property (p_grant_held) else $error("grant without cpu hold");
  property p_grant_release; $fell(dma_hold_req) |-> ##[0:1] !dma_hold_grant; endproperty
  a_grant_release: assert property (p_grant_release) else $error("grant kept after release");
  property p_back_to_refresh; $fell(dma_hold_grant) && tick_seen_ff |-> ##[0:4] refresh_cycle; endproperty
  a_back_to_refresh: assert property (p_back_to_refresh) else $error("refresh not resumed");
  property p_pending_served; $rose(tick_seen_ff) && !dma_hold_grant |-> ##[0:12] refresh_cycle; endproperty
  a_pending_served: assert property (p_pending_served) else $error("pending tick not served");
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rda_pkg::*;
  `define CHK(nm, ex, got) begin tests_run++; if ((ex) !== (got)) begin bad_count++; \
    $display("Error %s exp %h got %h", nm, ex, got); end end

  logic        i_clk_sys;
  logic        i_reset_n;
  logic        dma_req;
  logic        word_xfer;
  logic [15:0] xfer_addr;
  logic        page_wr;
  logic [7:0]  page_data;
  logic [23:0] dma_addr;
  logic        addr_valid;
  logic [7:0]  next_row;
  logic        pend;
  logic        busy;
  logic        dev_grant;
  logic        cpu_held;
  logic [7:0]  exp_row;
  logic [7:0]  row_seen;
  logic [7:0]  pend_row;
  logic        rc_d;
  int          bad_count;
  int          tests_run;
  int          cyc;
  int          n_ref;
  int          t0;
  int          last_tick;

  rda_if bus ();
  rda_arbiter u_rda_arbiter (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus), .o_dma_sys_addr(dma_addr),
    .o_dma_addr_valid(addr_valid), .o_next_row(next_row), .o_refresh_pending(pend), .o_refresh_busy(busy));
  rda_partner u_rda_partner (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus), .i_dev_dma_request(dma_req),
    .i_word_xfer(word_xfer), .i_xfer_addr(xfer_addr), .i_page_wr(page_wr), .i_page_data(page_data),
    .o_dev_dma_grant(dev_grant), .o_cpu_held(cpu_held));
  rda_assertions u_rda_assertions (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .refresh_tick(bus.refresh_tick),
    .cpu_hold_req(bus.cpu_hold_req), .cpu_hold_ack(bus.cpu_hold_ack), .refresh_cycle(bus.refresh_cycle),
    .sys_mem_read_n(bus.sys_mem_read_n), .row_addr_out(bus.row_addr_out), .row_addr_oe_n(bus.row_addr_oe_n),
    .dma_hold_req(bus.dma_hold_req), .dma_hold_grant(bus.dma_hold_grant), .sys_addr_lo(bus.sys_addr_lo));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // page load, then one dma transfer; returns row seen at grant
  task automatic dma_xfer(input logic word, input logic [15:0] addr, input logic [7:0] page,
                          input logic [23:0] exp, output logic [7:0] row);
    @(posedge i_clk_sys);
    page_wr <= 1'b1;
    page_data <= page;
    @(posedge i_clk_sys);
    page_wr <= 1'b0;
    word_xfer <= word;
    xfer_addr <= addr;
    repeat (2) @(posedge i_clk_sys);
    dma_req <= 1'b1;
    do @(posedge i_clk_sys); while (addr_valid !== 1'b1);
    row = next_row;
    `CHK("dma address", exp, dma_addr)
    `CHK("peripheral grant", 1'b1, dev_grant)
    `CHK("cpu held", 1'b1, cpu_held)
    `CHK("word controller", word, bus.dma_word)
    dma_req <= 1'b0;
    do @(posedge i_clk_sys); while (bus.dma_hold_grant !== 1'b0);
  endtask

  // ---------------------------------------------------------------
  // clock, timeout, refresh monitor
  // ---------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      wrap_up();
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset_n && bus.refresh_tick) begin
      if (last_tick != 0) `CHK("tick gap", TICK_CYCLES, cyc - last_tick)
      last_tick = cyc;
    end
    if (i_reset_n && bus.refresh_cycle && !rc_d) begin
      `CHK("refresh row", exp_row, bus.sys_addr_lo)
      `CHK("busy flag", 1'b1, busy)
      if (n_ref == 0) t0 = cyc;
      if (n_ref == ROWS_SHORT) `CHK("short sweep", 1'b1, (cyc - t0) * 50 <= RETAIN_SHORT_NS)
      if (n_ref == ROWS_LONG) `CHK("long sweep", 1'b1, (cyc - t0) * 50 <= RETAIN_LONG_NS)
      exp_row++;
      n_ref++;
    end
    rc_d = bus.refresh_cycle;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    dma_req = 1'b0;
    word_xfer = 1'b0;
    xfer_addr = 16'h0000;
    page_wr = 1'b0;
    page_data = 8'h00;
    exp_row = ROW_RESET;
    rc_d = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    #1;
    `CHK("row after reset", ROW_RESET, next_row)
    `CHK("lines released", 1'b1, bus.row_addr_oe_n)
    `CHK("read strobe idle", 1'b1, bus.sys_mem_read_n)
    dma_xfer(1'b0, 16'hfffe, 8'hff, 24'hfffffe, row_seen);
    dma_xfer(1'b1, 16'h1235, 8'h81, {7'h40, 16'h1235, 1'b0}, row_seen);
    do @(posedge i_clk_sys); while (bus.refresh_tick !== 1'b1);
    pend_row = next_row + 8'h01;
    #1;
    `CHK("tick pending", 1'b1, pend)
    dma_xfer(1'b0, 16'h0100, 8'h00, 24'h000100, row_seen);
    `CHK("refresh before dma", pend_row, row_seen)
    // dma placed so that a tick lands during the grant (k=0), during hold wait (k=1), before the request (k=2)
    for (int k = 0; k < 3; k++) begin
      do @(posedge i_clk_sys); while (bus.refresh_tick !== 1'b1);
      repeat (290 + 3 * k) @(posedge i_clk_sys);
      dma_xfer(1'b0, 16'h4321, 8'h12, 24'h124321, row_seen);
    end
    while (n_ref <= ROWS_LONG) @(posedge i_clk_sys);
    wrap_up();
  end
endmodule
